// ===== verilog/arith_seq_consts.svh
`ifndef ARITH_SEQ_CONSTS_SVH
`define ARITH_SEQ_CONSTS_SVH
// How it works
// - Decrement command sets initiate, extend and second-probe flops before probing
// - Decrement probes: borrow, third, fourth; fourth clears flops and resumes
// - Borrow hits lowest stage: accumulator minus one, operand untouched
// - Borrow out of top stage sets the zero flag for the translator
// - Masked add adds operand AND mask as positive 36-bit, complements mask
// - Masked start sets delayed-add, masked-initiate, extend; forms AND product
// - Step one clears delayed-add; step two adds operand, clears it, sets restore flop
// - Step three complements cleared operand to ones, clears restore flop
// - Step four clears extend, copies mask into operand, clears mask
// - Step five complements operand and sets fifth-probe flop
// - Step six clears masked-initiate, operand to mask, clears operand, resumes
// - Shift rotates the accumulator left by the loaded count
// - Zero count at start produces no signals and no wait
// - Nonzero count returns wait-shift and sets shift-left-initiate flop
// - Each controlled pulse shifts left one and decrements the counter
// - Pulse finding count one ends shift, clears flop, resumes
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_ACC0 8'h08
`define OFS_ACC1 8'h0c
`define OFS_ACC2 8'h10
`define OFS_OP0 8'h14
`define OFS_OP1 8'h18
`define OFS_MASK0 8'h1c
`define OFS_MASK1 8'h20
`define OFS_SHCNT 8'h24
`define CMD_DEC 2'h1
`define CMD_MADD 2'h2
`define CMD_SHIFT 2'h3
`define ST_BUSY 0
`define ST_ZERO 1
`define ST_SHIFT 2
`define ZERO_CLR_BIT 1
`define STEP_LAST 2'h3
`define ACC_RST 72'h0
`define WORD36_RST 36'h0
`define SHCNT_RST 7'h00
`endif

// ===== verilog/arith_seq_pkg.sv
package arith_seq_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_DEC_B, S_DEC_C, S_DEC_D,
    S_MA1, S_MA2, S_MA3, S_MA4, S_MA5, S_MA6, S_SHIFT
  } seq_state_t;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } av_req_t;
  typedef struct packed {
    logic init_dec;
    logic extend;
    logic bprobe;
    logic delayed_add;
    logic masked_init;
    logic restore_op;
    logic fifth_probe;
    logic shl_init;
  } seq_flops_t;
endpackage

// ===== verilog/arith_sequencer.sv
`timescale 1ns/1ns
`include "arith_seq_consts.svh"
module arith_sequencer
  import arith_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire av_req_t avs_req,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  output logic resume_pulse,
  output logic wait_shift,
  output logic acc_zero
);

  ////////////////////////////////////////////////////////////
  // Helpers
  // Byte-lane merge for partial writes
  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
    input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Circular left shift by one place
  function automatic logic [71:0] rotl1(input logic [71:0] a);
    return {a[70:0], a[71]};
  endfunction

  ////////////////////////////////////////////////////////////
  // State
  seq_state_t st_reg, st_next;
  seq_flops_t fl_reg, fl_next;
  logic [71:0] acc_reg, acc_next;
  logic [35:0] op_reg, op_next;
  logic [35:0] mask_reg, mask_next;
  logic [6:0] cnt_reg, cnt_next;
  logic zero_reg, zero_next;
  logic resume_reg, resume_next;
  logic wshift_reg, wshift_next;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [1:0] div_reg;

  ////////////////////////////////////////////////////////////
  // Bus decode
  // Request is taken on the edge where waitrequest is low
  wire req = avs_req.read | avs_req.write;
  wire take = req & ~wait_reg;
  wire wtake = take & avs_req.write;
  wire idle = (st_reg == S_IDLE);
  wire [7:0] adr = avs_req.address;
  wire cmd_go = wtake & (adr == `OFS_CMD);
  wire [1:0] cmd = avs_req.writedata[1:0];
  wire zero_clr = wtake & (adr == `OFS_STATUS) & avs_req.writedata[`ZERO_CLR_BIT];
  // Data writes are ignored while a sequence runs
  wire dwr = wtake & idle;
  wire tick = (div_reg == `STEP_LAST);
  logic [31:0] rdata;
  wire [31:0] merged = be_merge(rdata, avs_req.writedata, avs_req.byteenable);

  // Read mux; unmapped offsets read as zero and match no write below
  always_comb begin
    rdata = 32'h0;
    if (adr == `OFS_STATUS) begin
      rdata[`ST_BUSY] = ~idle;
      rdata[`ST_ZERO] = zero_reg;
      rdata[`ST_SHIFT] = fl_reg.shl_init;
    end else if (adr == `OFS_ACC0) begin
      rdata = acc_reg[31:0];
    end else if (adr == `OFS_ACC1) begin
      rdata = acc_reg[63:32];
    end else if (adr == `OFS_ACC2) begin
      rdata = {24'h0, acc_reg[71:64]};
    end else if (adr == `OFS_OP0) begin
      rdata = op_reg[31:0];
    end else if (adr == `OFS_OP1) begin
      rdata = {28'h0, op_reg[35:32]};
    end else if (adr == `OFS_MASK0) begin
      rdata = mask_reg[31:0];
    end else if (adr == `OFS_MASK1) begin
      rdata = {28'h0, mask_reg[35:32]};
    end else if (adr == `OFS_SHCNT) begin
      rdata = {25'h0, cnt_reg};
    end
  end

  ////////////////////////////////////////////////////////////
  // Sequencer next state
  // Every step waits for the interval tick, one step per tick
  always_comb begin
    st_next = st_reg;
    fl_next = fl_reg;
    acc_next = acc_reg;
    op_next = op_reg;
    mask_next = mask_reg;
    cnt_next = cnt_reg;
    zero_next = zero_reg & ~zero_clr;
    resume_next = 1'b0;
    wshift_next = 1'b0;
    // Register loads from software
    if (dwr) begin
      if (adr == `OFS_ACC0) begin
        acc_next[31:0] = merged;
      end else if (adr == `OFS_ACC1) begin
        acc_next[63:32] = merged;
      end else if (adr == `OFS_ACC2) begin
        acc_next[71:64] = merged[7:0];
      end else if (adr == `OFS_OP0) begin
        op_next[31:0] = merged;
      end else if (adr == `OFS_OP1) begin
        op_next[35:32] = merged[3:0];
      end else if (adr == `OFS_MASK0) begin
        mask_next[31:0] = merged;
      end else if (adr == `OFS_MASK1) begin
        mask_next[35:32] = merged[3:0];
      end else if (adr == `OFS_SHCNT) begin
        cnt_next = merged[6:0];
      end
    end
    case (st_reg)
      S_IDLE: begin
        // Commands only start from idle
        if (cmd_go && cmd == `CMD_DEC) begin
          fl_next.init_dec = 1'b1;
          fl_next.extend = 1'b1;
          fl_next.bprobe = 1'b1;
          st_next = S_DEC_B;
        end else if (cmd_go && cmd == `CMD_MADD) begin
          fl_next.delayed_add = 1'b1;
          fl_next.masked_init = 1'b1;
          fl_next.extend = 1'b1;
          op_next = op_reg & mask_reg;
          st_next = S_MA1;
        end else if (cmd_go && cmd == `CMD_SHIFT && cnt_reg != 7'h00) begin
          wshift_next = 1'b1;
          fl_next.shl_init = 1'b1;
          st_next = S_SHIFT;
        end
      end
      S_DEC_B: begin
        if (tick) begin // Artificial borrow into stage zero
          acc_next = acc_reg - 72'h1;
          fl_next.bprobe = 1'b0;
          if (acc_reg == 72'h0) begin
            zero_next = 1'b1;
          end
          st_next = S_DEC_C;
        end
      end
      S_DEC_C: begin
        if (tick) begin
          st_next = S_DEC_D;
        end
      end
      S_DEC_D: begin
        if (tick) begin
          fl_next.init_dec = 1'b0;
          fl_next.extend = 1'b0;
          resume_next = 1'b1;
          st_next = S_IDLE;
        end
      end
      S_MA1: begin
        if (tick) begin
          fl_next.delayed_add = 1'b0;
          st_next = S_MA2;
        end
      end
      S_MA2: begin
        if (tick) begin // Left half always fed: operand taken as positive
          acc_next = acc_reg + {36'h0, op_reg};
          op_next = `WORD36_RST;
          fl_next.restore_op = 1'b1;
          st_next = S_MA3;
        end
      end
      S_MA3: begin
        if (tick) begin
          op_next = ~op_reg;
          fl_next.restore_op = 1'b0;
          st_next = S_MA4;
        end
      end
      S_MA4: begin
        if (tick) begin
          fl_next.extend = 1'b0;
          op_next = op_reg & mask_reg;
          mask_next = `WORD36_RST;
          st_next = S_MA5;
        end
      end
      S_MA5: begin
        if (tick) begin
          op_next = ~op_reg;
          fl_next.fifth_probe = 1'b1;
          st_next = S_MA6;
        end
      end
      S_MA6: begin
        if (tick) begin
          fl_next.masked_init = 1'b0;
          fl_next.fifth_probe = 1'b0;
          mask_next = op_reg;
          op_next = `WORD36_RST;
          resume_next = 1'b1;
          st_next = S_IDLE;
        end
      end
      S_SHIFT: begin // Controlled pulse is the interval tick
        if (tick) begin
          acc_next = rotl1(acc_reg);
          cnt_next = cnt_reg - 7'h01;
          if (cnt_reg == 7'h01) begin
            fl_next.shl_init = 1'b0;
            resume_next = 1'b1;
            st_next = S_IDLE;
          end
        end
      end
      default: begin
        st_next = S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////
  // Flip-flops
  // Free-running divider keeps a fixed step pitch; bus gets one wait cycle, then accept
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 2'h0;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
      wait_reg <= ~(req & wait_reg);
      if (req & wait_reg) begin
        rdata_reg <= rdata;
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= S_IDLE;
      fl_reg <= '0;
      acc_reg <= `ACC_RST;
      op_reg <= `WORD36_RST;
      mask_reg <= `WORD36_RST;
      cnt_reg <= `SHCNT_RST;
      zero_reg <= 1'b0;
      resume_reg <= 1'b0;
      wshift_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      fl_reg <= fl_next;
      acc_reg <= acc_next;
      op_reg <= op_next;
      mask_reg <= mask_next;
      cnt_reg <= cnt_next;
      zero_reg <= zero_next;
      resume_reg <= resume_next;
      wshift_reg <= wshift_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign resume_pulse = resume_reg;
  assign wait_shift = wshift_reg;
  assign acc_zero = zero_reg;

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_dec_go;
    idle && cmd_go && cmd == `CMD_DEC;
  endsequence
  sequence s_ma_go;
    idle && cmd_go && cmd == `CMD_MADD;
  endsequence
  sequence s_dec_done;
    st_reg == S_DEC_D && tick ##1 resume_reg;
  endsequence

  a_dec_flops_set: assert property (
    s_dec_go |=> fl_reg.init_dec && fl_reg.extend && fl_reg.bprobe && st_reg == S_DEC_B)
    else $error("decrement flops not set");
  a_dec_minus_one: assert property (
    st_reg == S_DEC_B && tick |=> acc_reg == $past(acc_reg) - 72'h1 && op_reg == $past(op_reg))
    else $error("decrement result wrong");
  a_zero_flag_set: assert property (
    st_reg == S_DEC_B && tick && acc_reg == 72'h0 |=> zero_reg)
    else $error("zero flag not set");
  a_dec_order_end: assert property (
    st_reg == S_DEC_B && tick |=> st_reg == S_DEC_C ##4 st_reg == S_DEC_D
      ##3 s_dec_done ##0 !fl_reg.init_dec && !fl_reg.extend)
    else $error("decrement did not end");
  a_mask_and_form: assert property (
    s_ma_go |=> op_reg == $past(op_reg & mask_reg) && fl_reg.extend
      && fl_reg.delayed_add && fl_reg.masked_init)
    else $error("masked start wrong");
  a_op_clear_restore: assert property (
    st_reg == S_MA2 && tick |=> op_reg == 36'h0 && fl_reg.restore_op
      && acc_reg == $past(acc_reg) + {36'h0, $past(op_reg)})
    else $error("masked add step wrong");
  a_op_all_ones: assert property (
    st_reg == S_MA3 && tick |=> op_reg == ~36'h0 && !fl_reg.restore_op)
    else $error("operand not all ones");
  a_mask_move_end: assert property (
    st_reg == S_MA6 && tick |=> resume_reg && op_reg == 36'h0
      && mask_reg == $past(op_reg) && !fl_reg.masked_init)
    else $error("masked add end wrong");
  a_shift_zero_none: assert property (
    idle && cmd_go && cmd == `CMD_SHIFT && cnt_reg == 7'h00
      |=> !wshift_reg && idle ##1 !resume_reg)
    else $error("zero count shift acted");
  a_shift_one_step: assert property (
    st_reg == S_SHIFT && tick |=> acc_reg == rotl1($past(acc_reg))
      && cnt_reg == $past(cnt_reg) - 7'h01)
    else $error("shift step wrong");
  a_shift_end_one: assert property (
    st_reg == S_SHIFT && tick && cnt_reg == 7'h01
      |=> resume_reg && !fl_reg.shl_init && cnt_reg == 7'h00)
    else $error("shift end wrong");

endmodule

// ===== tb/pulse_distributor_model.sv
`timescale 1ns/1ns
module pulse_distributor_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic resume_pulse,
  input wire logic wait_shift,
  output int resume_count,
  output int wait_count,
  output logic held
);
  // Distributor stalls from a shift wait until resume; counts expose every pulse
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      resume_count <= 0;
      wait_count <= 0;
      held <= 1'b0;
    end else begin
      if (wait_shift)
        wait_count <= wait_count + 1;
      if (resume_pulse)
        resume_count <= resume_count + 1;
      held <= (held | wait_shift) & ~resume_pulse;
    end
  end
endmodule

// ===== tb/tb_arith_sequencer.sv
`timescale 1ns/1ns
`include "arith_seq_consts.svh"
module tb_arith_sequencer
  import arith_seq_pkg::*;
;
  logic core_clk;
  logic reset_n;
  av_req_t req;
  logic avs_waitrequest;
  logic [31:0] avs_readdata;
  logic resume_pulse;
  logic wait_shift;
  logic acc_zero;
  int resume_count;
  int wait_count;
  logic held;
  int fails = 0;
  int tests_run = 0;
  int exp_res = 0;
  int exp_wait = 0;
  logic [71:0] pat;
  int kset[4] = '{1, 4, 72, 0};

  ////////////////////////////////////////////////////////////////////////
  arith_sequencer uut (.core_clk(core_clk), .reset_n(reset_n), .avs_req(req),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .resume_pulse(resume_pulse), .wait_shift(wait_shift), .acc_zero(acc_zero));
  pulse_distributor_model far (.core_clk(core_clk), .reset_n(reset_n),
    .resume_pulse(resume_pulse), .wait_shift(wait_shift),
    .resume_count(resume_count), .wait_count(wait_count), .held(held));

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon access; held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hf};
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    q = avs_readdata;
    req <= '0;
    @(posedge core_clk);
    if (n == 20) begin
      fails++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask

  task automatic set_acc(input logic [71:0] v);
    wr(`OFS_ACC0, v[31:0]);
    wr(`OFS_ACC1, v[63:32]);
    wr(`OFS_ACC2, {24'h0, v[71:64]});
  endtask

  task automatic chk_acc(input logic [71:0] v);
    rd(`OFS_ACC0, v[31:0], "acc0");
    rd(`OFS_ACC1, v[63:32], "acc1");
    rd(`OFS_ACC2, {24'h0, v[71:64]}, "acc2");
  endtask

  task automatic set_x(input logic [7:0] a, input logic [35:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h04, {28'h0, v[35:32]});
  endtask

  task automatic chk_x(input logic [7:0] a, input logic [35:0] v, input string what);
    rd(a, v[31:0], what);
    rd(a + 8'h04, {28'h0, v[35:32]}, what);
  endtask

  // Polls busy; a sequence that never ends is a failure, not a hang
  task automatic wait_idle;
    logic [31:0] q;
    int n;
    for (n = 0; n < 200; n++) begin
      bus(1'b0, `OFS_STATUS, 32'h0, q);
      if (q[`ST_BUSY] === 1'b0)
        break;
    end
    if (n == 200) begin
      fails++;
      close_out();
    end
    repeat (8) @(posedge core_clk);
  endtask

  task automatic cmd(input logic [1:0] c);
    wr(`OFS_CMD, {30'h0, c});
  endtask

  function automatic logic [71:0] rol(input logic [71:0] v, input int k);
    return (v << k) | (v >> (72 - k));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, then decrement, masked add and shift scenarios
  initial begin
    req = '0;
    reset_n = 1'b0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(`OFS_STATUS, 32'h0, "status");
    chk_acc(72'h0);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0, "unmapped");
    // Decrement; a data write while busy must be dropped
    set_acc(72'h5);
    set_x(`OFS_OP0, 36'h9_12345678);
    cmd(`CMD_DEC);
    wr(`OFS_ACC0, 32'h77);
    rd(`OFS_STATUS, 32'h1, "busy");
    wait_idle();
    exp_res++;
    chk_acc(72'h4);
    chk_x(`OFS_OP0, 36'h9_12345678, "op_dec");
    check("acc_zero", {31'h0, acc_zero}, 32'h0);
    check("resumes", resume_count, exp_res);
    // Borrow runs through all 72 stages
    set_acc(72'h0);
    cmd(`CMD_DEC);
    wait_idle();
    exp_res++;
    chk_acc({72{1'b1}});
    check("acc_zero", {31'h0, acc_zero}, 32'h1);
    rd(`OFS_STATUS, 32'h2, "zero_flag");
    wr(`OFS_STATUS, 32'h2);
    check("zero_clr", {31'h0, acc_zero}, 32'h0);
    check("resumes", resume_count, exp_res);
    // Masked add twice, second with the complemented mask; acc preloaded first
    set_acc(72'hffffffff);
    set_x(`OFS_OP0, 36'hf_0000ff00);
    set_x(`OFS_MASK0, 36'ha_ffff0f0f);
    cmd(`CMD_MADD);
    wait_idle();
    exp_res++;
    chk_acc(72'hb_00000eff);
    chk_x(`OFS_OP0, 36'h0, "op_madd");
    chk_x(`OFS_MASK0, 36'h5_0000f0f0, "mask_madd");
    set_x(`OFS_OP0, 36'hf_ffffffff);
    cmd(`CMD_MADD);
    wait_idle();
    exp_res++;
    chk_acc(72'h10_0000ffef);
    chk_x(`OFS_MASK0, 36'ha_ffff0f0f, "mask_madd2");
    check("resumes", resume_count, exp_res);
    // Shift table: short, long, full turn and zero count
    pat = 72'h96_0123abcd_80000001;
    foreach (kset[i]) begin
      set_acc(pat);
      wr(`OFS_SHCNT, kset[i]);
      cmd(`CMD_SHIFT);
      // Counts of four and more are still running when this read is sampled
      if (kset[i] > 3) begin
        rd(`OFS_STATUS, 32'h5, "shifting");
        check("held_busy", {31'h0, held}, 32'h1);
      end
      wait_idle();
      if (kset[i] != 0) begin
        exp_res++;
        exp_wait++;
      end
      chk_acc(rol(pat, kset[i]));
      rd(`OFS_SHCNT, 32'h0, "shcnt");
      check("waits", wait_count, exp_wait);
      check("resumes", resume_count, exp_res);
      check("held", {31'h0, held}, 32'h0);
    end
    close_out();
  end
endmodule
